// >>> core/bdc_pkg.sv
// Constants, register indices and types of the buffer copy/checksum engine.
// Assumes a byte-wide register port and a synchronous 8-Kbyte buffer memory.
// Functional notes
// - Start loads source counter from start pair
// - Source steps by one, wraps at rx end
// - Stop when source counter equals end pair
// - Go clear aborts, registers stay unchanged
// - Unreachable end runs forever, no timeout
// - Start equal end walks whole buffer
// - Destination linear, wraps 8191 to 0
// - Copy start waits while transmit request set
// - Copy end: clear go, set done
// - Copy takes two cycles per byte
// - Sum bytes big-endian pairs, odd padded zero
// - Result inverts end-around-carry 16-bit sum
// - Sum end: clear go, done, store result
// - Sum takes one cycle per byte
// - Interrupt needs engine and global enables
// - Address registers 13 bits, split low/high
// - Unimplemented register bits read zero
// - Abort also sets done flag
// - Done flag holds until cleared or reset
// - Interrupt pin driven low when active

package bdc_pkg;

	localparam int BDC_ADDR_W = 13;
	localparam int BDC_REG_AW = 4;

	////////////////////////////////////////////////////////////////////////
	// Register indices on the register port
	localparam logic [3:0] BDC_IDX_IRQ_EN = 4'h0;
	localparam logic [3:0] BDC_IDX_IRQ_FLAG = 4'h1;
	localparam logic [3:0] BDC_IDX_CTRL = 4'h2;
	localparam logic [3:0] BDC_IDX_RXEND_L = 4'h3;
	localparam logic [3:0] BDC_IDX_RXEND_H = 4'h4;
	localparam logic [3:0] BDC_IDX_START_L = 4'h5;
	localparam logic [3:0] BDC_IDX_START_H = 4'h6;
	localparam logic [3:0] BDC_IDX_END_L = 4'h7;
	localparam logic [3:0] BDC_IDX_END_H = 4'h8;
	localparam logic [3:0] BDC_IDX_DEST_L = 4'h9;
	localparam logic [3:0] BDC_IDX_DEST_H = 4'ha;
	localparam logic [3:0] BDC_IDX_SUM_L = 4'hb;
	localparam logic [3:0] BDC_IDX_SUM_H = 4'hc;
	localparam logic [3:0] BDC_IDX_RXST_L = 4'hd;
	localparam logic [3:0] BDC_IDX_RXST_H = 4'he;

	////////////////////////////////////////////////////////////////////////
	// Bit positions and high-byte width
	localparam int BDC_BIT_GLOBAL_IE = 7;
	localparam int BDC_BIT_DONE_IE = 5;
	localparam int BDC_BIT_DONE_FLAG = 5;
	localparam int BDC_BIT_GO = 5;
	localparam int BDC_BIT_SUM_MODE = 4;
	localparam int BDC_BIT_TX_REQ = 3;
	localparam int BDC_HIGH_W = 5;

	////////////////////////////////////////////////////////////////////////
	// Reset values and sum pad byte
	localparam logic [7:0] BDC_RST_BYTE = 8'h00;
	localparam logic [12:0] BDC_RST_ADDR = 13'h0000;
	localparam logic [15:0] BDC_RST_SUM = 16'h0000;
	localparam logic [7:0] BDC_PAD_BYTE = 8'h00;

	typedef enum logic [1:0] {
		BDC_IDLE,
		BDC_WAIT_TX,
		BDC_RUN
	} bdc_state_t;

endpackage

// >>> core/bdc_fifo.sv
// Byte FIFO between the buffer read side and the write or sum side.
// Assumes one clock; output data come from a register (show-ahead stage).
`timescale 1ns/1ps
`default_nettype none

module bdc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int CW = $clog2(DEPTH) + 1
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic flush_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out,
	output logic [CW-1:0] count_out
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [CW-1:0] cnt_q;
	logic out_valid_q;
	logic [WIDTH-1:0] out_data_q;
	logic push;
	logic take;
	logic bypass;
	logic from_mem;
	logic to_mem;

	assign in_ready_out = (cnt_q != CW'(DEPTH));
	assign push = in_valid_in && in_ready_out;
	// Output stage may load when empty or being popped
	assign take = !out_valid_q || out_ready_in;
	assign from_mem = take && (cnt_q != '0);
	assign bypass = take && (cnt_q == '0) && push;
	assign to_mem = push && !bypass;
	assign out_valid_out = out_valid_q;
	assign out_data_out = out_data_q;
	assign count_out = cnt_q + CW'(out_valid_q);

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in) begin
		if (to_mem) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in || flush_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
		end else begin
			if (to_mem) begin
				wr_ptr_q <= wr_ptr_q + PW'(1);
			end
			if (from_mem) begin
				rd_ptr_q <= rd_ptr_q + PW'(1);
			end
			cnt_q <= cnt_q + CW'(to_mem) - CW'(from_mem);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in || flush_in) begin
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end else if (from_mem) begin
			out_valid_q <= 1'b1;
			out_data_q <= mem_q[rd_ptr_q];
		end else if (bypass) begin
			out_valid_q <= 1'b1;
			out_data_q <= in_data_in;
		end else if (take) begin
			out_valid_q <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// >>> core/bdc_top.sv
// Copy and checksum engine working inside the 8-Kbyte packet buffer.
// Assumes a same-clock register port and a buffer port whose read data
// arrive one cycle after the read strobe; transmit engine drives TX_REQ_IN.
`timescale 1ns/1ps
`default_nettype none

module bdc_top
	import bdc_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic [BDC_REG_AW-1:0] REG_ADDR_IN,
	input wire logic REG_WR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	output logic [7:0] REG_RDATA_OUT,
	input wire logic TX_REQ_IN,
	output logic [BDC_ADDR_W-1:0] MEM_ADDR_OUT,
	output logic MEM_RD_OUT,
	output logic MEM_WR_OUT,
	output logic [7:0] MEM_WDATA_OUT,
	input wire logic [7:0] MEM_RDATA_IN,
	output logic BUSY_OUT,
	output logic INT_N_OUT
);

	localparam int CW = $clog2(FIFO_DEPTH) + 1;

	////////////////////////////////////////////////////////////////////////
	// Functions
	function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		oc_add = s[15:0] + {15'h0000, s[16]};
	endfunction

	function automatic logic [12:0] wr_pair(input logic [12:0] cur, input logic lo_wr,
		input logic hi_wr, input logic [7:0] d);
		wr_pair = cur;
		if (lo_wr) begin
			wr_pair[7:0] = d;
		end
		if (hi_wr) begin
			wr_pair[12:8] = d[BDC_HIGH_W-1:0];
		end
	endfunction

	function automatic logic wr_at(input logic we, input logic [3:0] a, input logic [3:0] idx);
		wr_at = we && (a == idx);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0] irq_en_q;
	logic done_q;
	logic go_q;
	logic sum_mode_q;
	logic [12:0] rx_end_q;
	logic [12:0] rx_start_q;
	logic [12:0] start_q;
	logic [12:0] end_q;
	logic [12:0] dest_q;
	logic [15:0] sum_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	bdc_state_t state_q;
	logic mode_q;
	logic [12:0] src_q;
	logic [12:0] dptr_q;
	logic first_q;
	logic rd_done_q;
	logic phase_q;
	logic rd_dly_q;
	logic [15:0] acc_q;
	logic [7:0] hi_q;
	logic hi_have_q;
	logic mem_rd_q;
	logic mem_wr_q;
	logic [12:0] mem_addr_q;
	logic [7:0] mem_wdata_q;
	logic int_n_q;
	logic busy_q;
	logic ctrl_wr;
	logic flag_wr;
	logic start_run;
	logic abort;
	logic fin;
	logic issue_rd;
	logic do_wr;
	logic pop;
	logic room;
	logic flush;
	logic [15:0] acc_final;
	logic [12:0] src_next;
	logic f_in_ready;
	logic f_valid;
	logic [7:0] f_data;
	logic [CW-1:0] f_count;

	assign ctrl_wr = wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_CTRL);
	assign flag_wr = wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_IRQ_FLAG);

	////////////////////////////////////////////////////////////////////////
	// Enable, control and pointer registers
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			irq_en_q <= BDC_RST_BYTE;
		end else if (wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_IRQ_EN)) begin
			irq_en_q <= REG_WDATA_IN;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			go_q <= 1'b0;
			sum_mode_q <= 1'b0;
		end else if (ctrl_wr) begin
			go_q <= REG_WDATA_IN[BDC_BIT_GO];
			sum_mode_q <= REG_WDATA_IN[BDC_BIT_SUM_MODE];
		end else if (fin) begin
			go_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			rx_end_q <= BDC_RST_ADDR;
			rx_start_q <= BDC_RST_ADDR;
			start_q <= BDC_RST_ADDR;
			end_q <= BDC_RST_ADDR;
			dest_q <= BDC_RST_ADDR;
		end else begin
			rx_end_q <= wr_pair(rx_end_q, wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_RXEND_L),
				wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_RXEND_H), REG_WDATA_IN);
			rx_start_q <= wr_pair(rx_start_q, wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_RXST_L),
				wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_RXST_H), REG_WDATA_IN);
			start_q <= wr_pair(start_q, wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_START_L),
				wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_START_H), REG_WDATA_IN);
			end_q <= wr_pair(end_q, wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_END_L),
				wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_END_H), REG_WDATA_IN);
			dest_q <= wr_pair(dest_q, wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_DEST_L),
				wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_DEST_H), REG_WDATA_IN);
		end
	end

	// The engine writes the result only at a normal sum finish, so an abort leaves it
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			sum_q <= BDC_RST_SUM;
		end else if (fin && mode_q) begin
			sum_q <= ~acc_final;
		end else begin
			if (wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_SUM_L)) begin
				sum_q[7:0] <= REG_WDATA_IN;
			end
			if (wr_at(REG_WR_IN, REG_ADDR_IN, BDC_IDX_SUM_H)) begin
				sum_q[15:8] <= REG_WDATA_IN;
			end
		end
	end

	// Set wins over a software clear in the same cycle
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			done_q <= 1'b0;
		end else if (fin || abort) begin
			done_q <= 1'b1;
		end else if (flag_wr && !REG_WDATA_IN[BDC_BIT_DONE_FLAG]) begin
			done_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register read-back, one cycle after the address
	always_comb begin
		rdata_d = BDC_RST_BYTE;
		case (REG_ADDR_IN)
			BDC_IDX_IRQ_EN: rdata_d = irq_en_q;
			BDC_IDX_IRQ_FLAG: rdata_d[BDC_BIT_DONE_FLAG] = done_q;
			BDC_IDX_CTRL: begin
				rdata_d[BDC_BIT_GO] = go_q;
				rdata_d[BDC_BIT_SUM_MODE] = sum_mode_q;
				rdata_d[BDC_BIT_TX_REQ] = TX_REQ_IN;
			end
			BDC_IDX_RXEND_L: rdata_d = rx_end_q[7:0];
			BDC_IDX_RXEND_H: rdata_d = {3'h0, rx_end_q[12:8]};
			BDC_IDX_RXST_L: rdata_d = rx_start_q[7:0];
			BDC_IDX_RXST_H: rdata_d = {3'h0, rx_start_q[12:8]};
			BDC_IDX_START_L: rdata_d = start_q[7:0];
			BDC_IDX_START_H: rdata_d = {3'h0, start_q[12:8]};
			BDC_IDX_END_L: rdata_d = end_q[7:0];
			BDC_IDX_END_H: rdata_d = {3'h0, end_q[12:8]};
			BDC_IDX_DEST_L: rdata_d = dest_q[7:0];
			BDC_IDX_DEST_H: rdata_d = {3'h0, dest_q[12:8]};
			BDC_IDX_SUM_L: rdata_d = sum_q[7:0];
			BDC_IDX_SUM_H: rdata_d = sum_q[15:8];
			default: rdata_d = BDC_RST_BYTE;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			rdata_q <= BDC_RST_BYTE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Engine control
	// No watchdog: a range whose end is never met keeps the engine busy
	assign start_run = (state_q == BDC_WAIT_TX) && go_q && !(TX_REQ_IN && !mode_q);
	assign abort = (state_q != BDC_IDLE) && !go_q;
	// Read stays ahead of the drain only while the FIFO has space in flight
	assign room = (f_count + CW'(mem_rd_q) + CW'(rd_dly_q)) < CW'(FIFO_DEPTH);
	assign issue_rd = (state_q == BDC_RUN) && go_q && !rd_done_q && room
		&& (mode_q || !phase_q);
	assign do_wr = (state_q == BDC_RUN) && go_q && !mode_q && phase_q && f_valid;
	assign pop = (state_q == BDC_RUN) && f_valid && (mode_q || phase_q);
	assign fin = (state_q == BDC_RUN) && go_q && rd_done_q && !mem_rd_q && !rd_dly_q
		&& !f_valid;
	assign flush = (state_q != BDC_RUN);
	assign src_next = (src_q == rx_end_q) ? rx_start_q : src_q + 13'h0001;
	assign acc_final = hi_have_q ? oc_add(acc_q, {hi_q, BDC_PAD_BYTE}) : acc_q;

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			state_q <= BDC_IDLE;
			mode_q <= 1'b0;
		end else begin
			case (state_q)
				BDC_IDLE: begin
					if (go_q) begin
						state_q <= BDC_WAIT_TX;
						mode_q <= sum_mode_q;
					end
				end
				BDC_WAIT_TX: begin
					if (abort) begin
						state_q <= BDC_IDLE;
					end else if (start_run) begin
						state_q <= BDC_RUN;
					end
				end
				BDC_RUN: begin
					if (abort || fin) begin
						state_q <= BDC_IDLE;
					end
				end
				default: state_q <= BDC_IDLE;
			endcase
		end
	end

	// Source walk; the first byte never ends the run, so start equal to end
	// goes all the way round the buffer before it meets the end again
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			src_q <= BDC_RST_ADDR;
			first_q <= 1'b0;
			rd_done_q <= 1'b0;
			phase_q <= 1'b0;
		end else if (start_run) begin
			src_q <= start_q;
			first_q <= 1'b1;
			rd_done_q <= 1'b0;
			phase_q <= 1'b0;
		end else if (state_q == BDC_RUN) begin
			phase_q <= !phase_q;
			if (issue_rd) begin
				first_q <= 1'b0;
				if ((src_q == end_q) && !first_q) begin
					rd_done_q <= 1'b1;
				end else begin
					src_q <= src_next;
				end
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			dptr_q <= BDC_RST_ADDR;
		end else if (start_run) begin
			dptr_q <= dest_q;
		end else if (do_wr) begin
			dptr_q <= dptr_q + 13'h0001;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			acc_q <= BDC_RST_SUM;
			hi_q <= BDC_RST_BYTE;
			hi_have_q <= 1'b0;
		end else if (start_run) begin
			acc_q <= BDC_RST_SUM;
			hi_have_q <= 1'b0;
		end else if (pop && mode_q) begin
			if (!hi_have_q) begin
				hi_q <= f_data;
				hi_have_q <= 1'b1;
			end else begin
				acc_q <= oc_add(acc_q, {hi_q, f_data});
				hi_have_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Buffer port; reads and copy writes fall on alternate cycles
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			mem_addr_q <= BDC_RST_ADDR;
			mem_wdata_q <= BDC_RST_BYTE;
			rd_dly_q <= 1'b0;
		end else begin
			mem_rd_q <= issue_rd;
			mem_wr_q <= do_wr;
			rd_dly_q <= mem_rd_q && (state_q == BDC_RUN) && go_q;
			if (issue_rd) begin
				mem_addr_q <= src_q;
			end else if (do_wr) begin
				mem_addr_q <= dptr_q;
				mem_wdata_q <= f_data;
			end
		end
	end

	bdc_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH),
		.CW(CW)
	) u_fifo (
		.clk_in(CLK_IN),
		.resetn_in(RESETN_IN),
		.flush_in(flush),
		.in_valid_in(rd_dly_q),
		.in_ready_out(f_in_ready),
		.in_data_in(MEM_RDATA_IN),
		.out_valid_out(f_valid),
		.out_ready_in(pop),
		.out_data_out(f_data),
		.count_out(f_count)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupt pin and status outputs
	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			int_n_q <= 1'b1;
			busy_q <= 1'b0;
		end else begin
			int_n_q <= !(done_q && irq_en_q[BDC_BIT_DONE_IE]
				&& irq_en_q[BDC_BIT_GLOBAL_IE]);
			busy_q <= (state_q != BDC_IDLE) && f_in_ready;
		end
	end

	assign REG_RDATA_OUT = rdata_q;
	assign MEM_ADDR_OUT = mem_addr_q;
	assign MEM_RD_OUT = mem_rd_q;
	assign MEM_WR_OUT = mem_wr_q;
	assign MEM_WDATA_OUT = mem_wdata_q;
	assign BUSY_OUT = busy_q;
	assign INT_N_OUT = int_n_q;

endmodule

`default_nettype wire

// >>> verif/bdc_top_properties.sv
// Concurrent checks on the copy and checksum engine's top-level ports.
// Assumes bdc_pkg is compiled first; bound into every instance of bdc_top.
`timescale 1ns/1ps
`default_nettype none

module bdc_checker
	import bdc_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic [BDC_REG_AW-1:0] REG_ADDR_IN,
	input wire logic REG_WR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic [7:0] REG_RDATA_OUT,
	input wire logic TX_REQ_IN,
	input wire logic [BDC_ADDR_W-1:0] MEM_ADDR_OUT,
	input wire logic MEM_RD_OUT,
	input wire logic MEM_WR_OUT,
	input wire logic [7:0] MEM_WDATA_OUT,
	input wire logic [7:0] MEM_RDATA_IN,
	input wire logic BUSY_OUT,
	input wire logic INT_N_OUT
);
	logic [7:0] en_q;
	logic [12:0] rxe_q;
	logic [12:0] rxs_q;
	logic go_wr;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	////////////////////////////////////////////////////////////////////////
	// Shadows of the registers the checks depend on
	assign go_wr = REG_WR_IN && (REG_ADDR_IN == BDC_IDX_CTRL) && REG_WDATA_IN[BDC_BIT_GO];

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			en_q <= 8'h00;
		end else if (REG_WR_IN && REG_ADDR_IN == BDC_IDX_IRQ_EN) begin
			en_q <= REG_WDATA_IN;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			rxe_q <= 13'h0000;
			rxs_q <= 13'h0000;
		end else if (REG_WR_IN) begin
			if (REG_ADDR_IN == BDC_IDX_RXEND_L) rxe_q[7:0] <= REG_WDATA_IN;
			if (REG_ADDR_IN == BDC_IDX_RXEND_H) rxe_q[12:8] <= REG_WDATA_IN[4:0];
			if (REG_ADDR_IN == BDC_IDX_RXST_L) rxs_q[7:0] <= REG_WDATA_IN;
			if (REG_ADDR_IN == BDC_IDX_RXST_H) rxs_q[12:8] <= REG_WDATA_IN[4:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequences; only sum mode reads in back-to-back cycles
	sequence rd_pair_s;
		MEM_RD_OUT ##1 MEM_RD_OUT;
	endsequence

	sequence wr_pair_s;
		MEM_WR_OUT ##2 MEM_WR_OUT;
	endsequence

	sequence go_idle_s;
		(go_wr && !BUSY_OUT) ##1 !TX_REQ_IN [*3];
	endsequence

	////////////////////////////////////////////////////////////////////////
	// Assertions
	port_excl_a: assert property (!(MEM_RD_OUT && MEM_WR_OUT))
		else $error("read and write strobes high together");
	write_spacing_a: assert property (MEM_WR_OUT |=> !MEM_WR_OUT)
		else $error("writes closer than two cycles");
	src_step_a: assert property (rd_pair_s |-> MEM_ADDR_OUT ==
		(($past(MEM_ADDR_OUT) == rxe_q) ? rxs_q : $past(MEM_ADDR_OUT) + 13'h0001))
		else $error("source address did not step or wrap");
	dest_step_a: assert property (wr_pair_s |-> MEM_ADDR_OUT == $past(MEM_ADDR_OUT, 2) + 13'h0001)
		else $error("destination address not linear");
	go_start_a: assert property (go_idle_s |-> ##[0:4] MEM_RD_OUT)
		else $error("operation did not start reading");
	int_enables_a: assert property (!INT_N_OUT |-> ($past(en_q) & 8'ha0) == 8'ha0)
		else $error("interrupt pin low without both enables");
	int_hold_a: assert property ((!INT_N_OUT && !$past(REG_WR_IN)) |=> !INT_N_OUT)
		else $error("interrupt released without a register write");
	high_byte_a: assert property ((REG_WR_IN && REG_ADDR_IN == BDC_IDX_START_H) ##1
		(REG_ADDR_IN == BDC_IDX_START_H) |=> REG_RDATA_OUT == ($past(REG_WDATA_IN, 2) & 8'h1f))
		else $error("start high byte readback wrong");
endmodule

bind bdc_top bdc_checker u_chk (
	.CLK_IN(CLK_IN),
	.RESETN_IN(RESETN_IN),
	.REG_ADDR_IN(REG_ADDR_IN),
	.REG_WR_IN(REG_WR_IN),
	.REG_WDATA_IN(REG_WDATA_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT),
	.TX_REQ_IN(TX_REQ_IN),
	.MEM_ADDR_OUT(MEM_ADDR_OUT),
	.MEM_RD_OUT(MEM_RD_OUT),
	.MEM_WR_OUT(MEM_WR_OUT),
	.MEM_WDATA_OUT(MEM_WDATA_OUT),
	.MEM_RDATA_IN(MEM_RDATA_IN),
	.BUSY_OUT(BUSY_OUT),
	.INT_N_OUT(INT_N_OUT)
);

`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the copy and checksum engine.
// Assumes bdc_pkg, bdc_fifo, bdc_top and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import bdc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic tx_req = 1'b0;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [12:0] mem_addr;
	logic mem_rd;
	logic mem_wr;
	logic [7:0] mem_wdata;
	logic busy;
	logic int_n;
	logic [7:0] mem [0:8191];
	int failures = 0;
	int compares = 0;
	int rd_cnt = 0;
	int wr_cnt = 0;
	int cycles = 0;
	// Rows: index, written byte, expected readback
	logic [19:0] rows [14] = '{
		{BDC_IDX_START_L, 8'ha5, 8'ha5}, {BDC_IDX_START_H, 8'hff, 8'h1f},
		{BDC_IDX_END_L, 8'h5a, 8'h5a}, {BDC_IDX_END_H, 8'hff, 8'h1f},
		{BDC_IDX_DEST_L, 8'h3c, 8'h3c}, {BDC_IDX_DEST_H, 8'hff, 8'h1f},
		{BDC_IDX_RXEND_L, 8'hc3, 8'hc3}, {BDC_IDX_RXEND_H, 8'hff, 8'h1f},
		{BDC_IDX_RXST_H, 8'hff, 8'h1f}, {BDC_IDX_SUM_L, 8'h12, 8'h12},
		{BDC_IDX_SUM_H, 8'hff, 8'hff}, {BDC_IDX_IRQ_EN, 8'hff, 8'hff},
		{BDC_IDX_IRQ_FLAG, 8'hff, 8'h00}, {4'hf, 8'hff, 8'h00}};

	bdc_top #(.FIFO_DEPTH(16)) DUT (
		.CLK_IN(clk),
		.RESETN_IN(rst_n),
		.REG_ADDR_IN(reg_addr),
		.REG_WR_IN(reg_wr),
		.REG_WDATA_IN(reg_wdata),
		.REG_RDATA_OUT(reg_rdata),
		.TX_REQ_IN(tx_req),
		.MEM_ADDR_OUT(mem_addr),
		.MEM_RD_OUT(mem_rd),
		.MEM_WR_OUT(mem_wr),
		.MEM_WDATA_OUT(mem_wdata),
		.MEM_RDATA_IN(mem_rdata),
		.BUSY_OUT(busy),
		.INT_N_OUT(int_n)
	);

	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// Buffer model; idle read data toggles so stale bytes never look valid
	always @(posedge clk) begin
		cycles++;
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
			wr_cnt++;
		end
		if (mem_rd) begin
			mem_rdata <= mem[mem_addr];
			rd_cnt++;
		end else begin
			mem_rdata <= ~mem_rdata;
		end
		if (cycles == 30000) begin
			failures++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tasks, all entered at a falling edge but the timeout call of print_verdict
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		@(negedge clk);
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
		reg_addr = a;
		@(negedge clk);
		chk({8'h00, reg_rdata}, {8'h00, e});
	endtask

	task automatic set_ptr(input logic [3:0] lo, input logic [12:0] v);
		wr(lo, v[7:0]);
		wr(lo + 4'h1, {3'h0, v[12:8]});
	endtask

	// Busy rises a few cycles after the go write, so let it land first
	task automatic wait_idle;
		repeat (4) @(negedge clk);
		while (busy !== 1'b0) @(negedge clk);
	endtask

	task automatic print_verdict;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		for (int i = 0; i < 8192; i++) mem[i] = i[7:0];
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		chk({15'h0, int_n}, 16'h0001);
		for (int i = 0; i < 16; i++) rdchk(i[3:0], 8'h00);
		foreach (rows[i]) begin
			wr(rows[i][19:16], rows[i][15:8]);
			rdchk(rows[i][19:16], rows[i][7:0]);
		end
		// Checksum over an odd range, then an even one
		mem[256] = 8'h89;
		mem[257] = 8'hab;
		mem[258] = 8'hcd;
		set_ptr(BDC_IDX_RXEND_L, 13'h1fff);
		set_ptr(BDC_IDX_RXST_L, 13'h0000);
		set_ptr(BDC_IDX_START_L, 13'h0100);
		set_ptr(BDC_IDX_END_L, 13'h0102);
		wr(BDC_IDX_IRQ_EN, 8'ha0);
		rd_cnt = 0;
		wr_cnt = 0;
		wr(BDC_IDX_CTRL, 8'h30);
		wait_idle();
		chk(16'(rd_cnt), 16'h0003);
		chk(16'(wr_cnt), 16'h0000);
		rdchk(BDC_IDX_SUM_L, 8'h53);
		rdchk(BDC_IDX_SUM_H, 8'ha9);
		rdchk(BDC_IDX_CTRL, 8'h10);
		rdchk(BDC_IDX_START_L, 8'h00);
		rdchk(BDC_IDX_IRQ_FLAG, 8'h20);
		chk({15'h0, int_n}, 16'h0000);
		wr(BDC_IDX_IRQ_FLAG, 8'h00);
		chk({15'h0, int_n}, 16'h0001);
		set_ptr(BDC_IDX_END_L, 13'h0101);
		wr(BDC_IDX_CTRL, 8'h30);
		wait_idle();
		rdchk(BDC_IDX_SUM_L, 8'h54);
		rdchk(BDC_IDX_SUM_H, 8'h76);
		// Copy held off by transmit, source wraps, destination wraps
		mem[64] = 8'h33;
		mem[65] = 8'h44;
		set_ptr(BDC_IDX_RXEND_L, 13'h0101);
		set_ptr(BDC_IDX_RXST_L, 13'h0040);
		set_ptr(BDC_IDX_END_L, 13'h0041);
		set_ptr(BDC_IDX_DEST_L, 13'h1ffe);
		wr(BDC_IDX_IRQ_FLAG, 8'h00);
		wr(BDC_IDX_IRQ_EN, 8'h20);
		tx_req = 1'b1;
		rd_cnt = 0;
		wr_cnt = 0;
		wr(BDC_IDX_CTRL, 8'h20);
		repeat (20) @(negedge clk);
		chk(16'(rd_cnt), 16'h0000);
		chk({15'h0, busy}, 16'h0001);
		rdchk(BDC_IDX_CTRL, 8'h28);
		tx_req = 1'b0;
		wait_idle();
		chk({8'h00, mem[8190]}, 16'h0089);
		chk({8'h00, mem[8191]}, 16'h00ab);
		chk({8'h00, mem[0]}, 16'h0033);
		chk({8'h00, mem[1]}, 16'h0044);
		chk({8'h00, mem[2]}, 16'h0002);
		chk(16'(wr_cnt), 16'h0004);
		rdchk(BDC_IDX_CTRL, 8'h00);
		rdchk(BDC_IDX_IRQ_FLAG, 8'h20);
		rdchk(BDC_IDX_SUM_L, 8'h54);
		chk({15'h0, int_n}, 16'h0001);
		// Start equal to end walks the whole buffer before it ends; abort it early
		set_ptr(BDC_IDX_RXEND_L, 13'h1fff);
		set_ptr(BDC_IDX_RXST_L, 13'h0000);
		set_ptr(BDC_IDX_START_L, 13'h0200);
		set_ptr(BDC_IDX_END_L, 13'h0200);
		set_ptr(BDC_IDX_DEST_L, 13'h1000);
		wr(BDC_IDX_IRQ_FLAG, 8'h00);
		wr(BDC_IDX_IRQ_EN, 8'ha0);
		wr(BDC_IDX_CTRL, 8'h20);
		repeat (40) @(negedge clk);
		chk({15'h0, busy}, 16'h0001);
		wr(BDC_IDX_CTRL, 8'h00);
		repeat (2) @(negedge clk);
		chk({15'h0, busy}, 16'h0000);
		rdchk(BDC_IDX_IRQ_FLAG, 8'h20);
		rdchk(BDC_IDX_START_H, 8'h02);
		rdchk(BDC_IDX_SUM_H, 8'h76);
		chk({15'h0, int_n}, 16'h0000);
		print_verdict();
	end
endmodule

`default_nettype wire
